// >>> tb/secp_master.sv
// spi master model, mode 0: sck idles low, data changes on fall, sampled on rise
module secp_master (
    input  wire logic mclk_i,
    input  wire logic so_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] txb [0:7];
    logic [7:0] rxb [0:7];

    // idle bus: deselected, clock standing low
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // one whole frame of n bytes; sck only runs inside the frame
    task automatic frame(input int n);
        int i;
        int b;
        @(posedge mclk_i);
        #1 cs_n_o = 1'b0;                      // frame opens at select fall
        #80;
        for (i = 0; i < n; i++) begin
            for (b = 7; b >= 0; b--) begin
                si_o = txb[i][b];              // msb first
                #80 sck_o = 1'b1;
                rxb[i][b] = so_i;
                #80 sck_o = 1'b0;
            end
        end
        #40 cs_n_o = 1'b1;                     // select rises in the low time after the lsb
        si_o = ~si_o;                          // released line never keeps its last value
        #80;
    endtask
endmodule

// >>> tb/secp_top_tb.sv
module secp_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk;
    logic       arst_n;
    logic       wp_n;
    wire        sck;
    wire        cs_n;
    wire        si;
    wire        so;
    wire        so_oe;
    wire        so_line;
    int         err_total;
    int         n_checks;
    logic [7:0] s;

    // serial output floats whenever the device does not drive it
    assign so_line = so_oe ? so : 1'bz;
    always #5 mclk = ~mclk;

    secp_top #(.ADDR_BITS(10), .WRITE_CYCLES(2000)) DUT (
        .mclk_i(mclk), .arst_n_i(arst_n), .sck_i(sck), .cs_n_i(cs_n),
        .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe));
    secp_master M (.mclk_i(mclk), .so_i(so_line), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

    task automatic results();
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    // bytes are taken from the top of w downwards
    task automatic fr(input logic [63:0] w, input int n);
        int i;
        for (i = 0; i < 8; i++) M.txb[i] = w[63-8*i -: 8];
        M.frame(n);
    endtask

    task automatic st();
        fr({8'h05, 56'h0}, 3);
        s = M.rxb[1];
    endtask

    task automatic wait_ready();
        int  k;
        logic done;
        done = 1'b0;
        for (k = 0; k < 40 && !done; k++) begin
            st();
            done = (s[0] === 1'b0);
        end
        if (!done) begin
            $display("ERROR ready wait expected 0 seen 1");
            err_total++;
            results();
        end
    endtask

    task automatic t_reset();
        st();
        chk("state after reset", 8'h00, s);
        chk("state repeat", 8'h00, M.rxb[2]);
        chk("so idle", {7'h0, 1'bz}, {7'h0, so_line});
    endtask

    task automatic t_latch();
        logic [7:0] ops [0:3];
        logic [7:0] exp [0:3];
        int i;
        ops = '{8'h06, 8'h04, 8'h0E, 8'h0C};
        exp = '{8'h02, 8'h00, 8'h02, 8'h00};
        for (i = 0; i < 4; i++) begin
            fr({ops[i], 56'h0}, 1);
            st();
            chk("latch bit", exp[i], s);
        end
    endtask

    task automatic t_write();
        fr({8'h06, 56'h0}, 1);
        fr({8'h02, 16'h03FE, 32'hA0A1A2A3, 8'h00}, 7);
        st();
        chk("state busy", 8'hFF, s);
        fr({8'h06, 56'h0}, 1);
        fr({8'h03, 16'h03FE, 40'h0}, 4);
        chk("read ignored while busy", 8'hzz, M.rxb[3]);
        wait_ready();
        st();
        chk("state after cycle", 8'h00, s);
        fr({8'h06, 56'h0}, 1);
        fr({8'h02, 16'h0000, 8'h5A, 32'h0}, 4);
        wait_ready();
        fr({8'h03, 16'h03FE, 40'h0}, 6);
        chk("read 3FE", 8'hA0, M.rxb[3]);
        chk("read 3FF", 8'hA1, M.rxb[4]);
        chk("read wrap 000", 8'h5A, M.rxb[5]);
        fr({8'h03, 16'h03E0, 40'h0}, 5);
        chk("page wrap 3E0", 8'hA2, M.rxb[3]);
        chk("page wrap 3E1", 8'hA3, M.rxb[4]);
    endtask

    task automatic t_nolatch();
        fr({8'h02, 16'h0000, 8'h11, 32'h0}, 4);
        st();
        chk("no cycle without latch", 8'h00, s);
        fr({8'h03, 16'h0000, 40'h0}, 4);
        chk("data kept", 8'h5A, M.rxb[3]);
    endtask

    task automatic t_protect();
        fr({8'h06, 56'h0}, 1);
        fr({8'h01, 8'h84, 48'h0}, 2);
        wait_ready();
        st();
        chk("guard stored", 8'h84, s);
        fr({8'h06, 56'h0}, 1);
        fr({8'h02, 16'h03FF, 8'h77, 32'h0}, 4);
        st();
        chk("guarded write refused", 8'h86, s);
        fr({8'h03, 16'h03FF, 40'h0}, 4);
        chk("guarded data kept", 8'hA1, M.rxb[3]);
        @(posedge mclk);
        #1 wp_n = 1'b0;
        fr({8'h01, 8'h00, 48'h0}, 2);
        st();
        chk("pin locked state", 8'h86, s);
        fr({8'h02, 16'h0000, 8'h3C, 32'h0}, 4);
        wait_ready();
        fr({8'h03, 16'h0000, 40'h0}, 4);
        chk("open page writable", 8'h3C, M.rxb[3]);
        @(posedge mclk);
        #1 wp_n = 1'b1;
        fr({8'h06, 56'h0}, 1);
        fr({8'h01, 8'h00, 48'h0}, 2);
        wait_ready();
        st();
        chk("pin enable cleared", 8'h00, s);
    endtask

    task automatic t_invalid();
        fr({8'h83, 56'h0}, 3);
        chk("so off after bad op", 8'hzz, M.rxb[1]);
        st();
        chk("restart after bad op", 8'h00, s);
    endtask

    // half and whole guard levels refuse writes in their region
    task automatic t_levels();
        fr({8'h06, 56'h0}, 1);
        fr({8'h01, 8'h08, 48'h0}, 2);
        wait_ready();
        fr({8'h06, 56'h0}, 1);
        fr({8'h02, 16'h0200, 8'h77, 32'h0}, 4);
        st();
        chk("half guard refused", 8'h0A, s);
        fr({8'h02, 16'h01FF, 8'h66, 32'h0}, 4);
        wait_ready();
        fr({8'h03, 16'h01FF, 40'h0}, 4);
        chk("below half writable", 8'h66, M.rxb[3]);
        fr({8'h06, 56'h0}, 1);
        fr({8'h01, 8'h0C, 48'h0}, 2);
        wait_ready();
        fr({8'h06, 56'h0}, 1);
        fr({8'h02, 16'h0000, 8'h77, 32'h0}, 4);
        st();
        chk("whole guard refused", 8'h0E, s);
    endtask

    // reset, then the scenarios in order
    initial begin
        mclk      = 1'b0;
        arst_n    = 1'b0;
        wp_n      = 1'b1;
        err_total = 0;
        n_checks  = 0;
        repeat (10) @(posedge mclk);
        #1 arst_n = 1'b1;
        repeat (8) @(posedge mclk);
        t_reset();
        t_latch();
        t_write();
        t_nolatch();
        t_protect();
        t_invalid();
        t_levels();
        results();
    end
endmodule

// >>> verilog/secp_mem.sv
module secp_mem #(
    parameter int WIDTH  = 8,
    parameter int ADDR_W = 5
)(
    input  wire logic mclk_i,
    secp_mem_if.mem   port_if
);
    logic [WIDTH-1:0] cells [2**ADDR_W];

    // one write and one registered read per cycle
    always_ff @(posedge mclk_i) begin
        if (port_if.wr_en) begin
            cells[port_if.wr_addr] <= port_if.wr_data;
        end
        if (port_if.rd_en) begin
            port_if.rd_data <= cells[port_if.rd_addr];
        end
    end
endmodule

// >>> verilog/secp_mem_if.sv
// write and registered read port of a small memory
interface secp_mem_if #(
    parameter int WIDTH  = 8,
    parameter int ADDR_W = 5
);
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [WIDTH-1:0]  wr_data;
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [WIDTH-1:0]  rd_data;

    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// >>> verilog/secp_pkg.sv
// Function
// - opcodes 0000x110 set latch, 0000x100 clear latch, 0000x101 read state
// - opcodes 0000x001 state write, 0000x011 array read, 0000x010 array write
// - all bytes travel msb first; every frame starts at chip select fall
// - write latch comes up cleared after power-up
// - clear-latch command disables programming regardless of write-guard pin
// - state bit 0 reads 1 while writing, 0 when ready
// - state bit 1 mirrors the write-enable latch
// - state bits 4 to 6 read 0 when idle; all bits read 1 while writing
// - block guard 00 none, 01 top quarter, 10 top half, 11 whole array
// - guard bits and pin enable are nonvolatile, need latch and timed cycle; reset here clears them to NV_RESET
// - hardware protected only when write-guard pin low and pin enable set
// - hardware protection rejects state writes and guarded array writes
// - array writes need latch set and an unguarded address
// - pin enable cannot be cleared while set and write-guard pin low
// - read: opcode, 16-bit address, then data shifts out, input ignored
// - continued read returns successive bytes, wrapping top to zero
// - during a write cycle only the state read is obeyed
// - write: opcode, address, data; programming starts at chip select rise
// - page write increments only five low address bits, wrapping in page
// - write latch clears when a write cycle completes
// - write without latch is discarded; standby at chip select rise
// - invalid opcode: no shifting in, output off until next select fall
// - chip select high: input ignored, output off
package secp_pkg;
    // clock and self-timed write duration
    localparam int CLK_MHZ       = 100;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;

    // array geometry
    localparam int ADDR_BITS_DEF = 13;
    localparam int PAGE_BITS     = 5;
    localparam int PAGE_BYTES    = 32;
    localparam int DATA_W        = 8;

    // opcode fields
    localparam logic [3:0] OP_UPPER       = 4'h0;
    localparam logic [2:0] OP_SET_LATCH   = 3'h6;
    localparam logic [2:0] OP_CLR_LATCH   = 3'h4;
    localparam logic [2:0] OP_STATE_READ  = 3'h5;
    localparam logic [2:0] OP_STATE_WRITE = 3'h1;
    localparam logic [2:0] OP_ARRAY_READ  = 3'h3;
    localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;

    // protection_and_busy_state fields
    localparam int ST_BUSY    = 0;
    localparam int ST_LATCH   = 1;
    localparam int ST_BG_LOW  = 2;
    localparam int ST_BG_HIGH = 3;
    localparam int ST_PIN_EN  = 7;
    localparam logic [7:0] ST_BUSY_VALUE = 8'hFF;

    // guard levels {block_guard_high, block_guard_low}
    localparam logic [1:0] GUARD_NONE    = 2'h0;
    localparam logic [1:0] GUARD_QUARTER = 2'h1;
    localparam logic [1:0] GUARD_HALF    = 2'h2;

    // nonvolatile bits {pin_protect_enable, block_guard_high, block_guard_low} at reset
    localparam logic [2:0] NV_RESET = 3'h0;

    typedef enum logic [2:0] {
        SECP_IDLE   = 3'h0,
        SECP_OPCODE = 3'h1,
        SECP_ADDR   = 3'h3,
        SECP_ARD    = 3'h2,
        SECP_AWR    = 3'h6,
        SECP_SRD    = 3'h7,
        SECP_SWR    = 3'h5,
        SECP_IGN    = 3'h4
    } secp_state_type;
endpackage

// >>> verilog/secp_top.sv
module secp_top #(
    parameter int ADDR_BITS    = secp_pkg::ADDR_BITS_DEF,
    parameter int WRITE_CYCLES = secp_pkg::WRITE_CYCLES
)(
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic si_i,
    input  wire logic wp_n_i,
    output logic      so_o,
    output logic      so_oe_o
);
    import secp_pkg::*;

    localparam int WC_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [WC_W-1:0] WC_LAST  = WC_W'(WRITE_CYCLES - 1);
    localparam logic [WC_W-1:0] WC_PAGE  = WC_W'(PAGE_BYTES);

    // protected region test for an address and a guard level
    function automatic logic in_guard(input logic [ADDR_BITS-1:0] a, input logic [1:0] lvl);
        case (lvl)
            GUARD_NONE:    in_guard = 1'b0;
            GUARD_QUARTER: in_guard = &a[ADDR_BITS-1:ADDR_BITS-2];
            GUARD_HALF:    in_guard = a[ADDR_BITS-1];
            default:       in_guard = 1'b1;
        endcase
    endfunction

    logic [1:0]           rst_pipe;
    logic                 rst_n;
    logic [3:0]           pin_m;
    logic [3:0]           pin_s;
    logic                 sck_q;
    logic                 cs_q;
    secp_state_type       state;
    secp_state_type       next_state;
    logic [2:0]           bit_cnt;
    logic [6:0]           rx_sh;
    logic [2:0]           cmd;
    logic                 addr_second;
    logic [ADDR_BITS-1:0] addr;
    logic                 wel;
    logic                 busy;
    logic [2:0]           nv;
    logic [2:0]           nv_new;
    logic                 nv_pend;
    logic                 page_prot;
    logic                 got_byte;
    logic [PAGE_BYTES-1:0] valid;
    logic [WC_W-1:0]      wc_cnt;
    logic                 copy_q;
    logic [PAGE_BITS-1:0] copy_idx;
    logic                 rd_go;
    logic                 load_q;
    logic [7:0]           tx_sh;
    logic [7:0]           st_idle;

    secp_mem_if #(.WIDTH(DATA_W), .ADDR_W(ADDR_BITS)) arr_if ();
    secp_mem_if #(.WIDTH(DATA_W), .ADDR_W(PAGE_BITS)) page_if ();

    secp_mem #(.WIDTH(DATA_W), .ADDR_W(ADDR_BITS)) u_array (
        .mclk_i  (mclk_i),
        .port_if (arr_if.mem)
    );
    secp_mem #(.WIDTH(DATA_W), .ADDR_W(PAGE_BITS)) u_page (
        .mclk_i  (mclk_i),
        .port_if (page_if.mem)
    );

    // reset release through two flops
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // two-flop synchronisers for sck, cs_n, si, wp_n, then edge history
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_m <= 4'h5;                                            // idle levels, so no false sck edge
            pin_s <= 4'h5;
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            pin_m <= {sck_i, cs_n_i, si_i, wp_n_i};
            pin_s <= pin_m;
            sck_q <= pin_s[3];
            cs_q  <= pin_s[2];
        end
    end

    // link decode
    wire sck_s     = pin_s[3];
    wire cs_s      = pin_s[2];
    wire si_s      = pin_s[1];
    wire wp_s      = pin_s[0];
    wire sck_rise  = sck_s & ~sck_q;
    wire sck_fall  = ~sck_s & sck_q;
    wire cs_fall   = ~cs_s & cs_q;
    wire cs_rise   = cs_s & ~cs_q;
    wire byte_done = sck_rise & (bit_cnt == 3'h7);
    wire [7:0] rx_byte  = {rx_sh, si_s};
    wire       op_valid = (rx_byte[7:4] == OP_UPPER);
    wire [2:0] op_code  = rx_byte[2:0];
    wire       op_done  = byte_done & (state == SECP_OPCODE);
    wire [15:0] addr_shift = {addr[7:0], rx_byte};
    wire [ADDR_BITS-1:0] addr_new = addr_shift[ADDR_BITS-1:0];
    wire       hw_prot  = ~wp_s & nv[2];
    wire       wr_start = cs_rise & (state == SECP_AWR) & (bit_cnt == 3'h0) & got_byte
                          & ~page_prot & wel;
    wire       sr_start = cs_rise & (state == SECP_SWR) & (bit_cnt == 3'h0) & got_byte
                          & ~hw_prot & wel;
    wire       wc_done  = busy & (wc_cnt == WC_LAST);
    wire       tx_state = (state == SECP_ARD) | (state == SECP_SRD);

    // protection_and_busy_state assembly
    always_comb begin
        st_idle             = 8'h00;
        st_idle[ST_LATCH]   = wel;
        st_idle[ST_BG_LOW]  = nv[0];
        st_idle[ST_BG_HIGH] = nv[1];
        st_idle[ST_PIN_EN]  = nv[2];
    end
    wire [7:0] status_byte = busy ? ST_BUSY_VALUE : st_idle;

    // frame sequencing
    always_comb begin
        next_state = state;
        if (cs_s) begin
            next_state = SECP_IDLE;
        end else if (cs_fall) begin
            next_state = SECP_OPCODE;
        end else if (byte_done) begin
            case (state)
                SECP_OPCODE: begin
                    if (!op_valid || (busy && op_code != OP_STATE_READ)) begin
                        next_state = SECP_IGN;
                    end else begin
                        case (op_code)
                            OP_STATE_READ:  next_state = SECP_SRD;
                            OP_STATE_WRITE: next_state = wel ? SECP_SWR : SECP_IGN;
                            OP_ARRAY_READ:  next_state = SECP_ADDR;
                            OP_ARRAY_WRITE: next_state = wel ? SECP_ADDR : SECP_IGN;
                            default:        next_state = SECP_IGN;
                        endcase
                    end
                end
                SECP_ADDR: begin
                    if (addr_second) begin
                        next_state = (cmd == OP_ARRAY_READ) ? SECP_ARD : SECP_AWR;
                    end
                end
                default: next_state = state;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= SECP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // bit shifter; idle and ignore frames take no input
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 3'h0;
            rx_sh   <= 7'h00;
        end else if (cs_s || cs_fall) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise && state != SECP_IGN && state != SECP_IDLE) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= rx_byte[6:0];
        end
    end

    // command, address and page bookkeeping
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmd         <= 3'h0;
            addr_second <= 1'b0;
            addr        <= '0;
            page_prot   <= 1'b0;
            got_byte    <= 1'b0;
            valid       <= '0;
            nv_new      <= NV_RESET;
            rd_go       <= 1'b0;
        end else begin
            rd_go <= 1'b0;
            if (cs_fall) begin
                got_byte <= 1'b0;
            end
            if (op_done) begin
                cmd         <= op_code;
                addr_second <= 1'b0;
                if (op_code == OP_ARRAY_WRITE && !busy) begin
                    valid <= '0;
                end
            end
            if (byte_done && state == SECP_ADDR) begin
                addr        <= addr_new;
                addr_second <= 1'b1;
                page_prot   <= in_guard(addr_new, nv[1:0]);
                rd_go       <= addr_second && cmd == OP_ARRAY_READ;
            end
            if (byte_done && state == SECP_ARD) begin
                rd_go <= 1'b1;
            end
            if (rd_go) begin
                addr <= addr + 1'b1;
            end
            if (byte_done && state == SECP_AWR) begin
                valid[addr[PAGE_BITS-1:0]] <= 1'b1;
                addr[PAGE_BITS-1:0]        <= addr[PAGE_BITS-1:0] + 1'b1;
                got_byte                   <= 1'b1;
            end
            if (byte_done && state == SECP_SWR) begin
                nv_new   <= {rx_byte[ST_PIN_EN], rx_byte[ST_BG_HIGH], rx_byte[ST_BG_LOW]};
                got_byte <= 1'b1;
            end
        end
    end

    // page buffer fill and drain into the array
    assign page_if.wr_en   = byte_done & (state == SECP_AWR);
    assign page_if.wr_addr = addr[PAGE_BITS-1:0];
    assign page_if.wr_data = rx_byte;
    assign page_if.rd_en   = busy & ~nv_pend & (wc_cnt < WC_PAGE);
    assign page_if.rd_addr = wc_cnt[PAGE_BITS-1:0];
    assign arr_if.wr_en    = copy_q & valid[copy_idx];
    assign arr_if.wr_addr  = {addr[ADDR_BITS-1:PAGE_BITS], copy_idx};
    assign arr_if.wr_data  = page_if.rd_data;
    assign arr_if.rd_en    = rd_go;
    assign arr_if.rd_addr  = addr;

    // write latch, self-timed cycle and nonvolatile bits
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            wel      <= 1'b0;
            busy     <= 1'b0;
            nv_pend  <= 1'b0;
            wc_cnt   <= '0;
            copy_q   <= 1'b0;
            copy_idx <= '0;
            nv       <= NV_RESET;
        end else begin
            copy_q   <= page_if.rd_en;
            copy_idx <= wc_cnt[PAGE_BITS-1:0];
            if (op_done && op_valid && !busy && op_code == OP_SET_LATCH) begin
                wel <= 1'b1;
            end
            if (op_done && op_valid && !busy && op_code == OP_CLR_LATCH) begin
                wel <= 1'b0;
            end
            if (wr_start || sr_start) begin
                busy    <= 1'b1;
                nv_pend <= sr_start;
                wc_cnt  <= '0;
            end else if (busy) begin
                wc_cnt <= wc_cnt + 1'b1;
            end
            if (wc_done) begin
                busy <= 1'b0;
                wel  <= 1'b0;
                if (nv_pend) begin
                    nv <= nv_new;
                end
            end
        end
    end

    // serial output: loaded per byte, shifted on sck fall
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            load_q  <= 1'b0;
            tx_sh   <= 8'h00;
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            load_q <= rd_go;
            if (load_q) begin
                tx_sh <= arr_if.rd_data;
            end else if (byte_done && next_state == SECP_SRD) begin
                tx_sh <= status_byte;
            end else if (sck_fall && tx_state) begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
            if (cs_s || !tx_state) begin
                so_oe_o <= 1'b0;
                so_o    <= 1'b0;
            end else if (sck_fall) begin
                so_oe_o <= 1'b1;
                so_o    <= tx_sh[7];
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    sequence s_write_request;
        cs_rise && state == SECP_AWR && bit_cnt == 3'h0 && got_byte;
    endsequence
    sequence s_cycle_begins;
        busy && wc_cnt == '0;
    endsequence

    property p_clear_latch;
        op_done && op_valid && !busy && op_code == OP_CLR_LATCH |=> !wel;
    endproperty
    a_clear_latch: assert property (p_clear_latch) else $error("latch not cleared");

    property p_busy_bit;
        busy |-> status_byte == ST_BUSY_VALUE;
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("status not all ones while busy");

    property p_idle_bits;
        !busy |-> status_byte[6:4] == 3'h0 && status_byte[ST_LATCH] == wel && !status_byte[ST_BUSY];
    endproperty
    a_idle_bits: assert property (p_idle_bits) else $error("idle status bits wrong");

    property p_program_needs_latch;
        s_write_request ##0 (!wel || page_prot) |=> !busy;
    endproperty
    a_program_needs_latch: assert property (p_program_needs_latch) else $error("write without latch");

    property p_program_starts;
        s_write_request ##0 (wel && !page_prot && !busy) |=> s_cycle_begins;
    endproperty
    a_program_starts: assert property (p_program_starts) else $error("write did not start");

    property p_state_write_guard;
        cs_rise && state == SECP_SWR && hw_prot |=> !nv_pend || !$rose(busy);
    endproperty
    a_state_write_guard: assert property (p_state_write_guard) else $error("guarded state write");

    property p_end_clears_latch;
        wc_done |=> !busy && !wel;
    endproperty
    a_end_clears_latch: assert property (p_end_clears_latch) else $error("latch kept after cycle");

    property p_busy_ignores;
        op_done && busy && op_code != OP_STATE_READ |=> state == SECP_IGN;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("command obeyed while busy");

    property p_cs_high_quiet;
        cs_s |=> !so_oe_o;
    endproperty
    a_cs_high_quiet: assert property (p_cs_high_quiet) else $error("output on while deselected");

    property p_page_wrap;
        byte_done && state == SECP_AWR |=>
            addr[PAGE_BITS-1:0] == $past(addr[PAGE_BITS-1:0]) + 5'h01 &&
            addr[ADDR_BITS-1:PAGE_BITS] == $past(addr[ADDR_BITS-1:PAGE_BITS]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page address step wrong");

    property p_read_wrap;
        rd_go && &addr |=> addr == '0;
    endproperty
    a_read_wrap: assert property (p_read_wrap) else $error("read address did not wrap");
endmodule
